// File: verilog/serial_time_string_broadcaster.sv
// Serial time-of-day broadcaster: one ASCII time string per second, with the
// carriage return launched on the rising edge of the second pulse.
// Assumes time fields, quality flags and the pulse come from logic on clock_i;
// only the serial receive pin is asynchronous.

// Behaviour
// - No strings before start character unless autostart
// - Stop character halts broadcast until restarted
// - One complete string per second while active
// - CR start bit within 100 us of pulse
// - SOH, day, semicolon, hours, minutes, seconds, quality
// - Quality followed by on-time CR, then LF
// - Day sent as three decimal digits
// - Space when time set and tracking
// - X when never set, F when flywheeling
// - Default line is 9600 8N1
// - Alternative line is 9600 8O1
// - Option suppresses the F quality flag
// - Autostart option begins broadcast after power-up
// - Options take effect only at restart
module serial_time_string_broadcaster #(
    parameter int BIT_CYCLES    = serial_time_pkg::BIT_CYCLES,
    parameter int SECOND_CYCLES = serial_time_pkg::SECOND_CYCLES
) (
    // Clock and reset.
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // Serial line.
    input  wire logic       serial_rx_i,
    output logic            serial_tx_o,
    // Time source.
    input  wire logic       second_pulse_i,
    input  wire logic [8:0] day_of_year_i,
    input  wire logic [4:0] hours_i,
    input  wire logic [5:0] minutes_i,
    input  wire logic [5:0] seconds_i,
    input  wire logic       time_set_i,
    input  wire logic       flywheel_i,
    // Options, taken once after reset.
    input  wire logic       parity_odd_i,
    input  wire logic       suppress_flag_i,
    input  wire logic       auto_start_i,
    // Status.
    output logic            broadcasting_o
);
    localparam int BC_W = $clog2(BIT_CYCLES + 1);
    localparam int SC_W = $clog2(SECOND_CYCLES + 1);
    localparam int LEAD_CYCLES = (serial_time_pkg::PRE_CHARS + serial_time_pkg::MARGIN_CHARS)
        * serial_time_pkg::FRAME_BITS_ODD * BIT_CYCLES;
    localparam logic [SC_W-1:0] SEND_POINT = SC_W'(SECOND_CYCLES - LEAD_CYCLES);
    localparam logic [BC_W-1:0] BIT_LAST   = BC_W'(BIT_CYCLES - 1);
    localparam logic [BC_W-1:0] BIT_HALF   = BC_W'(BIT_CYCLES / 2);

    // Converts 0..99 into two ASCII digits.
    function automatic logic [15:0] two_digits(input logic [6:0] v);
        logic [3:0] tens;
        logic [6:0] rest;
        tens = 4'h0;
        rest = v;
        for (int i = 0; i < 9; i++)
        begin
            if (rest >= 7'd10)
            begin
                rest = rest - 7'd10;
                tens = tens + 4'h1;
            end
        end
        return {serial_time_pkg::CH_ZERO + {4'h0, tens},
                serial_time_pkg::CH_ZERO + {1'b0, rest}};
    endfunction

    // Receive synchroniser and decoder.
    logic            rx_meta_reg;
    logic            rx_sync_reg;
    serial_time_pkg::rx_state_e rx_state_reg, rx_state_next;
    logic [BC_W-1:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0]      rx_bits_reg, rx_bits_next;
    logic [8:0]      rx_sh_reg, rx_sh_next;
    logic            rx_done;
    logic [7:0]      rx_byte;

    // Options and broadcast enable.
    logic cfg_loaded_reg, cfg_loaded_next;
    logic parity_odd_reg, parity_odd_next;
    logic suppress_reg, suppress_next;
    logic active_reg, active_next;
    logic is_start, is_stop;

    // Second timing and transmitter.
    logic            pulse_prev_reg;
    logic            pulse_rise;
    logic [SC_W-1:0] sec_cnt_reg, sec_cnt_next;
    serial_time_pkg::tx_state_e tx_state_reg, tx_state_next;
    logic [3:0]      idx_reg, idx_next;
    logic [7:0]      text_reg [0:13];
    logic [7:0]      text_next [0:13];
    logic [10:0]     tx_sh_reg, tx_sh_next;
    logic [3:0]      tx_bits_reg, tx_bits_next;
    logic [BC_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic            tx_busy;
    logic            load;
    logic [7:0]      load_char;
    logic            trigger;

    always_ff @(posedge clock_i)
    begin
        rx_meta_reg <= serial_rx_i;
        rx_sync_reg <= rx_meta_reg;
    end

    // Receiver sampling at mid-bit; parity is accepted but not checked.
    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_cnt_next   = (rx_cnt_reg == '0) ? BIT_LAST : rx_cnt_reg - BC_W'(1);
        rx_bits_next  = rx_bits_reg;
        rx_sh_next    = rx_sh_reg;
        rx_done       = 1'b0;
        rx_byte       = parity_odd_reg ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
        unique case (rx_state_reg)
            serial_time_pkg::RX_IDLE:
            begin
                rx_cnt_next = BIT_HALF;
                if (!rx_sync_reg)
                    rx_state_next = serial_time_pkg::RX_START;
            end
            serial_time_pkg::RX_START:
            begin
                if (rx_cnt_reg == '0)
                begin
                    rx_state_next = rx_sync_reg ? serial_time_pkg::RX_IDLE
                                                : serial_time_pkg::RX_DATA;
                    rx_bits_next  = parity_odd_reg ? 4'(serial_time_pkg::DATA_BITS + 1)
                                                   : 4'(serial_time_pkg::DATA_BITS);
                end
            end
            serial_time_pkg::RX_DATA:
            begin
                if (rx_cnt_reg == '0)
                begin
                    rx_sh_next   = {rx_sync_reg, rx_sh_reg[8:1]};
                    rx_bits_next = rx_bits_reg - 4'h1;
                    if (rx_bits_reg == 4'h1)
                        rx_state_next = serial_time_pkg::RX_STOP;
                end
            end
            serial_time_pkg::RX_STOP:
            begin
                if (rx_cnt_reg == '0)
                begin
                    rx_state_next = serial_time_pkg::RX_IDLE;
                    rx_done       = rx_sync_reg;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            rx_state_reg <= serial_time_pkg::RX_IDLE;
            rx_cnt_reg   <= '0;
            rx_bits_reg  <= 4'h0;
            rx_sh_reg    <= 9'h000;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_bits_reg  <= rx_bits_next;
            rx_sh_reg    <= rx_sh_next;
        end
    end

    assign is_start = rx_done && (rx_byte == serial_time_pkg::CH_START_LC
                               || rx_byte == serial_time_pkg::CH_START_UC);
    assign is_stop  = rx_done && (rx_byte == serial_time_pkg::CH_STOP_LC
                               || rx_byte == serial_time_pkg::CH_STOP_UC);

    // Options are taken once after reset, so a change needs a restart.
    always_comb
    begin
        cfg_loaded_next = 1'b1;
        parity_odd_next = cfg_loaded_reg ? parity_odd_reg : parity_odd_i;
        suppress_next   = cfg_loaded_reg ? suppress_reg : suppress_flag_i;
        active_next     = active_reg;
        if (!cfg_loaded_reg)
            active_next = auto_start_i;
        else if (is_start)
            active_next = 1'b1;
        else if (is_stop)
            active_next = 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            cfg_loaded_reg <= 1'b0;
            parity_odd_reg <= 1'b0;
            suppress_reg   <= 1'b0;
            active_reg     <= 1'b0;
        end
        else
        begin
            cfg_loaded_reg <= cfg_loaded_next;
            parity_odd_reg <= parity_odd_next;
            suppress_reg   <= suppress_next;
            active_reg     <= active_next;
        end
    end

    assign broadcasting_o = active_reg;
    assign pulse_rise     = second_pulse_i && !pulse_prev_reg;
    assign tx_busy        = tx_bits_reg != 4'h0;
    assign serial_tx_o    = tx_sh_reg[0];

    // The string is launched a fixed lead before the expected pulse, so the
    // carriage return only waits for the edge; a stop takes effect between strings.
    assign trigger = active_reg && sec_cnt_reg == SEND_POINT;

    always_comb
    begin
        logic [15:0] hh;
        logic [15:0] mm;
        logic [15:0] ss;
        logic [15:0] dd;
        logic [3:0]  hund;
        logic [8:0]  drem;
        hh   = two_digits(7'(hours_i));
        mm   = two_digits(7'(minutes_i));
        ss   = two_digits(7'(seconds_i));
        hund = (day_of_year_i >= 9'd300) ? 4'h3 : (day_of_year_i >= 9'd200) ? 4'h2
             : (day_of_year_i >= 9'd100) ? 4'h1 : 4'h0;
        // The hundreds product needs nine bits; an eight-bit product wraps for days 300 and up.
        drem = day_of_year_i - (9'(hund) * 9'h064);
        dd   = two_digits(drem[6:0]);
        sec_cnt_next = pulse_rise ? '0
                     : (sec_cnt_reg == SC_W'(SECOND_CYCLES)) ? sec_cnt_reg
                     : sec_cnt_reg + SC_W'(1);
        text_next = text_reg;
        if (trigger && tx_state_reg == serial_time_pkg::TX_IDLE)
        begin
            text_next[0]  = serial_time_pkg::CH_SOH;
            text_next[1]  = serial_time_pkg::CH_ZERO + {4'h0, hund};
            text_next[2]  = dd[15:8];
            text_next[3]  = dd[7:0];
            text_next[4]  = serial_time_pkg::CH_SEMI;
            text_next[5]  = hh[15:8];
            text_next[6]  = hh[7:0];
            text_next[7]  = serial_time_pkg::CH_COLON;
            text_next[8]  = mm[15:8];
            text_next[9]  = mm[7:0];
            text_next[10] = serial_time_pkg::CH_COLON;
            text_next[11] = ss[15:8];
            text_next[12] = ss[7:0];
            if (!time_set_i)
                text_next[13] = serial_time_pkg::CH_X;
            else if (flywheel_i && !suppress_reg)
                text_next[13] = serial_time_pkg::CH_F;
            else
                text_next[13] = serial_time_pkg::CH_SPACE;
        end
    end

    // Character sequencer and shifter.
    always_comb
    begin
        tx_state_next = tx_state_reg;
        idx_next      = idx_reg;
        load          = 1'b0;
        load_char     = (idx_reg == serial_time_pkg::IDX_CR) ? serial_time_pkg::CH_CR
                      : (idx_reg == serial_time_pkg::IDX_LF) ? serial_time_pkg::CH_LF
                      : text_reg[idx_reg];
        unique case (tx_state_reg)
            serial_time_pkg::TX_IDLE:
            begin
                idx_next = serial_time_pkg::IDX_SOH;
                if (trigger)
                    tx_state_next = serial_time_pkg::TX_SEND;
            end
            serial_time_pkg::TX_SEND:
            begin
                if (!tx_busy)
                begin
                    load     = 1'b1;
                    idx_next = idx_reg + 4'h1;
                    if (idx_reg == serial_time_pkg::IDX_QUALITY)
                        tx_state_next = serial_time_pkg::TX_HOLD;
                    else if (idx_reg == serial_time_pkg::IDX_LF)
                        tx_state_next = serial_time_pkg::TX_IDLE;
                end
            end
            serial_time_pkg::TX_HOLD:
            begin
                if (pulse_rise && !tx_busy)
                begin
                    load          = 1'b1;
                    idx_next      = serial_time_pkg::IDX_LF;
                    tx_state_next = serial_time_pkg::TX_SEND;
                end
            end
            default:
                tx_state_next = serial_time_pkg::TX_IDLE;
        endcase
        tx_sh_next   = tx_sh_reg;
        tx_bits_next = tx_bits_reg;
        tx_cnt_next  = tx_cnt_reg;
        if (load)
        begin
            // Without parity the eleventh bit is a second stop level never clocked out.
            tx_sh_next   = {1'b1, parity_odd_reg ? ~^load_char : 1'b1,
                            load_char, 1'b0};
            tx_bits_next = parity_odd_reg ? 4'(serial_time_pkg::FRAME_BITS_ODD)
                                          : 4'(serial_time_pkg::FRAME_BITS_NONE);
            tx_cnt_next  = BIT_LAST;
        end
        else if (tx_busy)
        begin
            tx_cnt_next = tx_cnt_reg - BC_W'(1);
            if (tx_cnt_reg == '0)
            begin
                tx_sh_next   = {1'b1, tx_sh_reg[10:1]};
                tx_bits_next = tx_bits_reg - 4'h1;
                tx_cnt_next  = BIT_LAST;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            pulse_prev_reg <= 1'b0;
            sec_cnt_reg    <= '0;
            tx_state_reg   <= serial_time_pkg::TX_IDLE;
            idx_reg        <= 4'h0;
            tx_sh_reg      <= 11'h7FF;
            tx_bits_reg    <= 4'h0;
            tx_cnt_reg     <= '0;
            for (int i = 0; i < 14; i++)
                text_reg[i] <= 8'h00;
        end
        else
        begin
            pulse_prev_reg <= second_pulse_i;
            sec_cnt_reg    <= sec_cnt_next;
            tx_state_reg   <= tx_state_next;
            idx_reg        <= idx_next;
            tx_sh_reg      <= tx_sh_next;
            tx_bits_reg    <= tx_bits_next;
            tx_cnt_reg     <= tx_cnt_next;
            text_reg       <= text_next;
        end
    end

    sequence s_cr_load;
        tx_state_reg == serial_time_pkg::TX_HOLD && pulse_rise && !tx_busy;
    endsequence
    sequence s_start_bit;
        !serial_tx_o [*8];
    endsequence

    property p_silent_when_stopped;
        @(posedge clock_i) disable iff (!nrst_i)
        tx_state_reg == serial_time_pkg::TX_IDLE && !active_reg |=>
            tx_state_reg == serial_time_pkg::TX_IDLE;
    endproperty
    a_silent_when_stopped: assert property (p_silent_when_stopped)
        else $error("String started while broadcast is off.");

    property p_stop_char;
        @(posedge clock_i) disable iff (!nrst_i)
        cfg_loaded_reg && is_stop |=> !active_reg;
    endproperty
    a_stop_char: assert property (p_stop_char)
        else $error("Stop character did not halt the broadcast.");

    property p_cr_on_time;
        @(posedge clock_i) disable iff (!nrst_i)
        s_cr_load |=> s_start_bit ##0 (tx_sh_reg[8:1] == serial_time_pkg::CH_CR);
    endproperty
    a_cr_on_time: assert property (p_cr_on_time)
        else $error("Carriage return not launched on the pulse edge.");

    property p_lf_follows_cr;
        @(posedge clock_i) disable iff (!nrst_i)
        s_cr_load |=> idx_reg == serial_time_pkg::IDX_LF
            && tx_state_reg == serial_time_pkg::TX_SEND;
    endproperty
    a_lf_follows_cr: assert property (p_lf_follows_cr)
        else $error("Line feed does not follow the carriage return.");

    property p_soh_first;
        @(posedge clock_i) disable iff (!nrst_i)
        tx_state_reg == serial_time_pkg::TX_IDLE && trigger |=>
            load && load_char == serial_time_pkg::CH_SOH;
    endproperty
    a_soh_first: assert property (p_soh_first)
        else $error("String does not open with start of header.");

    property p_quality;
        @(posedge clock_i) disable iff (!nrst_i)
        load && idx_reg == serial_time_pkg::IDX_QUALITY |->
            (load_char == serial_time_pkg::CH_SPACE || load_char == serial_time_pkg::CH_X
             || (load_char == serial_time_pkg::CH_F && !suppress_reg));
    endproperty
    a_quality: assert property (p_quality)
        else $error("Illegal or suppressed quality character sent.");

    property p_autostart;
        @(posedge clock_i) disable iff (!nrst_i)
        !cfg_loaded_reg |=> active_reg == $past(auto_start_i);
    endproperty
    a_autostart: assert property (p_autostart)
        else $error("Autostart option not applied after reset.");

    property p_options_frozen;
        @(posedge clock_i) disable iff (!nrst_i)
        cfg_loaded_reg |=> $stable(parity_odd_reg) && $stable(suppress_reg);
    endproperty
    a_options_frozen: assert property (p_options_frozen)
        else $error("Options changed without a restart.");

    property p_idle_high;
        @(posedge clock_i) disable iff (!nrst_i)
        !tx_busy |-> serial_tx_o;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("Serial line not idle high between characters.");

    property p_frame_length;
        @(posedge clock_i) disable iff (!nrst_i)
        load |=> tx_bits_reg == (parity_odd_reg ? 4'(serial_time_pkg::FRAME_BITS_ODD)
                                                : 4'(serial_time_pkg::FRAME_BITS_NONE));
    endproperty
    a_frame_length: assert property (p_frame_length)
        else $error("Frame length does not match the parity option.");

endmodule

// File: verilog/serial_time_pkg.sv
// Constants, character codes and state encodings of the serial time broadcaster.
// Assumes a single 10 MHz system clock shared by every user of the package.
package serial_time_pkg;

    // Clock and line timing.
    localparam int CLOCK_HZ           = 10_000_000;
    localparam int BAUD_RATE          = 9600;
    localparam int BIT_CYCLES         = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam int SECOND_US          = 1_000_000;
    localparam int SECOND_CYCLES      = SECOND_US * (CLOCK_HZ / 1_000_000);
    localparam int CR_DEADLINE_US     = 100;
    localparam int CR_DEADLINE_CYCLES = CR_DEADLINE_US * (CLOCK_HZ / 1_000_000);

    // Frame layout.
    localparam int DATA_BITS       = 8;
    localparam int FRAME_BITS_NONE = 10;
    localparam int FRAME_BITS_ODD  = 11;

    // String layout: characters sent ahead of the pulse, then CR and LF.
    localparam int PRE_CHARS    = 14;
    localparam int MARGIN_CHARS = 2;
    localparam logic [3:0] IDX_SOH     = 4'h0;
    localparam logic [3:0] IDX_QUALITY = 4'hD;
    localparam logic [3:0] IDX_CR      = 4'hE;
    localparam logic [3:0] IDX_LF      = 4'hF;

    // Character codes.
    localparam logic [7:0] CH_SOH   = 8'h01;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_SEMI  = 8'h3B;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_X     = 8'h58;
    localparam logic [7:0] CH_F     = 8'h46;
    localparam logic [7:0] CH_START_LC = 8'h63;
    localparam logic [7:0] CH_START_UC = 8'h43;
    localparam logic [7:0] CH_STOP_LC  = 8'h72;
    localparam logic [7:0] CH_STOP_UC  = 8'h52;

    typedef enum logic [1:0]
    {
        TX_IDLE = 2'h0,
        TX_SEND = 2'h1,
        TX_HOLD = 2'h3
    } tx_state_e;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } rx_state_e;

endpackage

// File: verification/host_model.sv
// Host computer on the serial line: sends command characters, decodes frames.
// Assumes the bench shares clock_i and sets odd_i before any traffic.
module host_model #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic clock_i,
    input  wire logic odd_i,
    input  wire logic line_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] rx_q[$];
    realtime    t_q[$];
    int         bad_frames = 0;

    initial line_o = 1'b1;

    // A frame always goes out whole, in the device's own line format.
    task automatic send_char(input logic [7:0] ch);
        logic [10:0] f;
        f = odd_i ? {1'b1, ~^ch, ch, 1'b0} : {2'b11, ch, 1'b0};
        @(posedge clock_i);
        #1;
        for (int i = 0; i < (odd_i ? 11 : 10); i++)
        begin
            line_o = f[i];
            repeat (BIT_CYCLES) @(posedge clock_i);
            #1;
        end
    endtask

    // Start time is taken at the first edge that sees the line low.
    initial
    begin : rx
        logic [7:0] d;
        realtime    t;
        forever
        begin
            @(posedge clock_i);
            if (line_i === 1'b0)
            begin
                t = $realtime;
                repeat (BIT_CYCLES / 2) @(posedge clock_i);
                for (int i = 0; i < 8; i++)
                begin
                    repeat (BIT_CYCLES) @(posedge clock_i);
                    d[i] = line_i;
                end
                if (odd_i)
                begin
                    repeat (BIT_CYCLES) @(posedge clock_i);
                    if ((^d ^ line_i) !== 1'b1) bad_frames++;
                end
                repeat (BIT_CYCLES) @(posedge clock_i);
                if (line_i !== 1'b1) bad_frames++;
                rx_q.push_back(d);
                t_q.push_back(t);
            end
        end
    end
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the serial time broadcaster with a host model.
// Assumes short bit and second counts; pulses come every SEC cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int BITS = 8;
    localparam int SEC  = 2000;

    logic    clk = 1'b0;
    logic    nrst = 1'b0;
    logic    pulse = 1'b0;
    logic    tset = 1'b0;
    logic    fly = 1'b0;
    logic    odd = 1'b0;
    logic    sup = 1'b0;
    logic    auto_on = 1'b0;
    logic [8:0] doy  = 9'h007;
    logic [4:0] hrs  = 5'h09;
    logic [5:0] mins = 6'h05;
    logic [5:0] secs = 6'h03;
    logic    host_line;
    logic    tx;
    logic    bcast;
    int      n_errors = 0;
    int      tests_run = 0;
    int      cyc = 0;
    realtime rise_t = 0;

    always #50 clk = ~clk;

    serial_time_string_broadcaster #(.BIT_CYCLES(BITS), .SECOND_CYCLES(SEC)) DUT (
        .clock_i(clk), .nrst_i(nrst), .serial_rx_i(host_line), .serial_tx_o(tx),
        .second_pulse_i(pulse), .day_of_year_i(doy), .hours_i(hrs),
        .minutes_i(mins), .seconds_i(secs), .time_set_i(tset), .flywheel_i(fly),
        .parity_odd_i(odd), .suppress_flag_i(sup), .auto_start_i(auto_on),
        .broadcasting_o(bcast));

    host_model #(.BIT_CYCLES(BITS)) host (
        .clock_i(clk), .odd_i(odd), .line_i(tx), .line_o(host_line));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The ceiling is about three times the expected run of roughly 20000 cycles.
    always @(posedge clk)
    begin
        #1;
        cyc++;
        pulse = (cyc % SEC) < 4;
        if (cyc % SEC == 0)
            rise_t = $realtime;
        if (cyc == 60000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic restart(input logic o, input logic s, input logic a);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        odd = o;
        sup = s;
        auto_on = a;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        host.rx_q.delete();
        host.t_q.delete();
    endtask

    // Lowest decimal digit of a value as an ASCII character.
    function automatic logic [7:0] asc(input int v);
        return 8'h30 + 8'(v % 10);
    endfunction

    // Partial frames left over from a reset are skipped up to the next header byte.
    task automatic get_str(input logic [7:0] q);
        logic [7:0] e[16];
        e = '{8'h01, asc(doy / 100), asc(doy / 10), asc(doy), 8'h3B,
              asc(hrs / 10), asc(hrs), 8'h3A, asc(mins / 10), asc(mins), 8'h3A,
              asc(secs / 10), asc(secs), q, 8'h0D, 8'h0A};
        for (int i = 0; i < 3 * SEC && host.rx_q.size() < 16; i++)
        begin
            @(posedge clk);
            #1;
            while (host.rx_q.size() > 0 && host.rx_q[0] !== 8'h01)
            begin
                void'(host.rx_q.pop_front());
                void'(host.t_q.pop_front());
            end
        end
        chk("string_len", 8'(host.rx_q.size()), 8'h10);
        for (int i = 0; i < 16 && i < host.rx_q.size(); i++)
            chk("string_char", host.rx_q[i], e[i]);
        if (host.rx_q.size() > 14)
            chk("cr_delay", {7'h00, host.t_q[14] > rise_t && host.t_q[14] - rise_t <= 100000.0},
                8'h01);
        host.rx_q.delete();
        host.t_q.delete();
    endtask

    task automatic quiet();
        int lows;
        lows = 0;
        repeat (2 * SEC)
        begin
            @(posedge clk);
            #1;
            if (tx !== 1'b1) lows++;
        end
        chk("quiet_line", 8'(lows), 8'h00);
    endtask

    task automatic t_cmd_gate();
        tset = 1'b0;
        restart(1'b0, 1'b0, 1'b0);
        quiet();
        chk("bcast_idle", {7'h00, bcast}, 8'h01 ^ 8'h01);
        host.send_char(8'h63);
        chk("bcast_on", {7'h00, bcast}, 8'h01);
        get_str(8'h58);
        host.send_char(8'h52);
        chk("bcast_off", {7'h00, bcast}, 8'h00);
        quiet();
        $display("test cmd_gate done");
    endtask

    task automatic t_odd_auto();
        tset = 1'b1;
        fly = 1'b1;
        restart(1'b1, 1'b1, 1'b1);
        chk("bcast_auto", {7'h00, bcast}, 8'h01);
        get_str(8'h20);
        sup = 1'b0;
        get_str(8'h20);
        host.send_char(8'h72);
        chk("bcast_stop", {7'h00, bcast}, 8'h00);
        $display("test odd_auto done");
    endtask

    task automatic t_quality();
        restart(1'b0, 1'b0, 1'b0);
        host.send_char(8'h43);
        chk("bcast_start", {7'h00, bcast}, 8'h01);
        get_str(8'h46);
        fly = 1'b0;
        doy = 9'h16E;
        hrs = 5'h17;
        mins = 6'h3B;
        secs = 6'h3B;
        get_str(8'h20);
        $display("test quality done");
    endtask

    initial
    begin
        t_cmd_gate();
        t_odd_auto();
        t_quality();
        chk("bad_frames", 8'(host.bad_frames), 8'h00);
        close_out();
    end
endmodule
